/* File: core/spio_ports.sv */
// The implementer's own choice: the plain strobed port.
`default_nettype none

module spio_ports
  import spio_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                ce,
  input  wire spio_bus_req_t       bus_req,
  output var  logic [DATA_W-1:0]   bus_rdata,
  input  wire logic [PA_W-1:0]     pa_pin_in,
  output var  logic [PA_W-1:0]     pa_pin_out,
  output var  logic [PA_W-1:0]     pa_pin_oe,
  output var  logic [PA_W-1:0]     pa_pin_level,
  input  wire logic [PB_W-1:0]     pb_pin_in,
  output var  logic [PB_W-1:0]     pb_pin_out,
  output var  logic [PB_W-1:0]     pb_pin_oe,
  input  wire logic [CHS_W-1:0]    analog_channel_select,
  output var  logic [PB_W-1:0]     adc_pin_connect,
  input  wire spio_timer_t         second_timer_unit,
  output var  logic [TMR_W-1:0]    second_timer_channel_pins
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Read mux shared by both ports: latch when driving, else pin or zero
  function automatic logic [7:0] rd_mux(
    input logic [7:0] latch,
    input logic [7:0] pin,
    input logic [7:0] dir,
    input logic [7:0] zero
  );
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      if (dir[i]) begin
        r[i] = latch[i];
      end else if (zero[i]) begin
        r[i] = 1'b0;
      end else begin
        r[i] = pin[i];
      end
    end
    return r;
  endfunction : rd_mux

  // Address compare used by every register access
  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] off
  );
    return a == off;
  endfunction : hit

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [PA_W-1:0]   pa_latch_ff;               // port_a_latch_bit, no reset
  logic [PA_W-1:0]   pa_dir_ff;                 // port_a_direction_bit
  logic [PB_W-1:0]   pb_latch_ff;               // port_b_pin_data latches, no reset
  logic [PB_W-1:0]   pb_dir_ff;                 // port_b_direction_bit
  logic [DATA_W-1:0] rdata_ff;                  // Read answer register
  logic [PA_W-1:0]   pa_out_ff;                 // Port A pin drive level
  logic [PA_W-1:0]   pa_oe_ff;                  // Port A buffer enables
  logic [PA_W-1:0]   pa_lvl_ff;                 // Port A level to shared units
  logic [PB_W-1:0]   pb_out_ff;                 // Port B pin drive level
  logic [PB_W-1:0]   pb_oe_ff;                  // Port B buffer enables
  logic [PB_W-1:0]   adc_con_ff;                // Converter switch per pin
  logic [TMR_W-1:0]  tmr_in_ff;                 // Capture level to the timer

  // ----------------------------------------------------------------
  // Synchronised pin levels
  // ----------------------------------------------------------------
  logic [PA_W-1:0] pa_sync;                     // Port A, clock domain
  logic [PB_W-1:0] pb_sync;                     // Port B, clock domain

  // Both ports share one chain so their levels are sampled together
  spio_sync #(
    .W (PA_W + PB_W)
  ) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .ce    (ce),
    .d     ({pb_pin_in, pa_pin_in}),
    .q     ({pb_sync, pa_sync})
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_pa_data;                             // Write to port A latches
  logic wr_pb_data;                             // Write to port B latches
  logic wr_pa_dir;                              // Write to port A direction
  logic wr_pb_dir;                              // Write to port B direction

  // Strobes qualified by address; the master never sees a wait
  always_comb begin
    wr_pa_data = 1'b0;
    wr_pb_data = 1'b0;
    wr_pa_dir  = 1'b0;
    wr_pb_dir  = 1'b0;
    if (bus_req.wr && hit(bus_req.addr, OFF_PA_DATA)) begin
      wr_pa_data = 1'b1;
    end else if (bus_req.wr && hit(bus_req.addr, OFF_PB_DATA)) begin
      wr_pb_data = 1'b1;
    end else if (bus_req.wr && hit(bus_req.addr, OFF_PA_DIR)) begin
      wr_pa_dir = 1'b1;
    end else if (bus_req.wr && hit(bus_req.addr, OFF_PB_DIR)) begin
      wr_pb_dir = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Shared pin ownership on port B
  // ----------------------------------------------------------------
  logic [PB_W-1:0] adc_sel;                     // Pin picked by the converter
  logic [PB_W-1:0] tmr_own;                     // Pin claimed by a timer channel
  logic [PB_W-1:0] tmr_out;                     // Timer level aligned to pins
  logic [PB_W-1:0] tmr_oe;                      // Timer enable aligned to pins

  // Select codes past the last pin belong to internal channels
  always_comb begin
    adc_sel = '0;
    if (analog_channel_select < CHS_W'(PB_W)) begin
      adc_sel[analog_channel_select[2:0]] = 1'b1;
    end
  end

  // Any non-zero edge/level code hands the pin to its channel
  always_comb begin
    tmr_own = '0;
    tmr_out = '0;
    tmr_oe  = '0;
    for (int j = 0; j < TMR_W; j++) begin
      tmr_own[TMR_LO+j] = |second_timer_unit.els[j];
      tmr_out[TMR_LO+j] = second_timer_unit.out[j];
      tmr_oe[TMR_LO+j]  = second_timer_unit.oe[j];
    end
  end

  // ----------------------------------------------------------------
  // Next pin drive for port B
  // ----------------------------------------------------------------
  logic [PB_W-1:0] nxt_pb_oe;                   // Buffer enable to register
  logic [PB_W-1:0] nxt_pb_out;                  // Drive level to register

  // Converter first, then timer, then the general-purpose direction.
  // The converter path is analog, so the digital buffer must stay off.
  always_comb begin
    nxt_pb_oe  = '0;
    nxt_pb_out = '0;
    for (int i = 0; i < PB_W; i++) begin
      if (adc_sel[i]) begin
        nxt_pb_oe[i]  = 1'b0;
        nxt_pb_out[i] = 1'b0;
      end else if (tmr_own[i]) begin
        nxt_pb_oe[i]  = tmr_oe[i];
        nxt_pb_out[i] = tmr_out[i];
      end else begin
        nxt_pb_oe[i]  = pb_dir_ff[i];
        nxt_pb_out[i] = pb_latch_ff[i] & pb_dir_ff[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Next read answer
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] nxt_rdata;                 // Value shown next cycle

  // Only the synchronised levels reach the read path
  always_comb begin
    nxt_rdata = RD_UNMAP;
    if (hit(bus_req.addr, OFF_PA_DATA)) begin
      nxt_rdata = rd_mux({1'b0, pa_latch_ff}, {1'b0, pa_sync},
                         {1'b0, pa_dir_ff}, 8'h00);
    end else if (hit(bus_req.addr, OFF_PB_DATA)) begin
      nxt_rdata = rd_mux(pb_latch_ff, pb_sync,
                         pb_dir_ff, adc_sel);
    end else if (hit(bus_req.addr, OFF_PA_DIR)) begin
      nxt_rdata = {1'b0, pa_dir_ff};
    end else if (hit(bus_req.addr, OFF_PB_DIR)) begin
      nxt_rdata = pb_dir_ff;
    end
  end

  // ----------------------------------------------------------------
  // Data latches
  // ----------------------------------------------------------------

  // No reset branch: the latches keep their contents through reset.
  // The pin drive registers below are reset, so no X reaches a pin.
  always_ff @(posedge clock) begin
    if (ce && wr_pa_data) begin
      pa_latch_ff <= bus_req.wdata[PA_W-1:0];
    end
  end

  // Port B latches likewise persist and take every write made while ce is high
  always_ff @(posedge clock) begin
    if (ce && wr_pb_data) begin
      pb_latch_ff <= bus_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Direction registers
  // ----------------------------------------------------------------

  // Port A direction, cleared by reset, bit seven dropped
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pa_dir_ff <= RST_PA_DIR;
    end else if (ce && wr_pa_dir) begin
      pa_dir_ff <= bus_req.wdata[PA_W-1:0];
    end
  end

  // Port B direction, cleared by reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pb_dir_ff <= RST_PB_DIR;
    end else if (ce && wr_pb_dir) begin
      pb_dir_ff <= bus_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------

  // Answer stands for exactly the cycle after the read strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= RST_RDATA;
    end else if (ce) begin
      if (bus_req.rd) begin
        rdata_ff <= nxt_rdata;
      end else begin
        rdata_ff <= RST_RDATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // Port A pin drive
  // ----------------------------------------------------------------

  // Registered drive costs one cycle of latency after a write, but
  // keeps every pin output glitch-free and straight from a flop.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pa_oe_ff  <= RST_PA_DIR;
      pa_out_ff <= '0;
    end else if (ce) begin
      pa_oe_ff  <= pa_dir_ff;
      pa_out_ff <= pa_latch_ff & pa_dir_ff;
    end
  end

  // Level seen by the serial and keypad units sharing port A
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pa_lvl_ff <= '0;
    end else if (ce) begin
      pa_lvl_ff <= pa_sync;
    end
  end

  // ----------------------------------------------------------------
  // Port B pin drive and shared-unit signals
  // ----------------------------------------------------------------

  // Buffer and level registered together so they switch as a pair
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pb_oe_ff  <= RST_PB_DIR;
      pb_out_ff <= '0;
    end else if (ce) begin
      pb_oe_ff  <= nxt_pb_oe;
      pb_out_ff <= nxt_pb_out;
    end
  end

  // Analog switch closes only on the pin the converter has selected
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      adc_con_ff <= '0;
    end else if (ce) begin
      adc_con_ff <= adc_sel;
    end
  end

  // Capture input is cut while the converter owns the pin, so a
  // late timer disable cannot see the analog level as edges.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tmr_in_ff <= '0;
    end else if (ce) begin
      for (int j = 0; j < TMR_W; j++) begin
        tmr_in_ff[j] <= pb_sync[TMR_LO+j] & ~adc_sel[TMR_LO+j];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus_rdata                 = rdata_ff;
  assign pa_pin_out                = pa_out_ff;
  assign pa_pin_oe                 = pa_oe_ff;
  assign pa_pin_level              = pa_lvl_ff;
  assign pb_pin_out                = pb_out_ff;
  assign pb_pin_oe                 = pb_oe_ff;
  assign adc_pin_connect           = adc_con_ff;
  assign second_timer_channel_pins = tmr_in_ff;

endmodule : spio_ports

`default_nettype wire

/* File: core/spio_pkg.sv */
`default_nettype none

package spio_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;          // Register address width
  localparam int unsigned DATA_W = 8;           // Register data width

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int unsigned PA_W   = 7;           // Port A pin count
  localparam int unsigned PB_W   = 8;           // Port B pin count
  localparam int unsigned TMR_W  = 2;           // Timer channels on port B
  localparam int unsigned CHS_W  = 5;           // Converter select width
  localparam int unsigned ELS_W  = 2;           // Edge/level field per channel
  localparam int unsigned TMR_LO = 6;           // First port B pin owned by timer
  localparam int unsigned SYNC_N = 2;           // Pin synchroniser depth

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_PA_DATA = 16'h0000;  // port_a_pin_data
  localparam logic [15:0] OFF_PB_DATA = 16'h0001;  // port_b_pin_data
  localparam logic [15:0] OFF_PA_DIR  = 16'h0004;  // port_a_direction
  localparam logic [15:0] OFF_PB_DIR  = 16'h0005;  // port_b_direction

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] RST_PA_DIR = 7'h00;    // All port A pins inputs
  localparam logic [7:0] RST_PB_DIR = 8'h00;    // All port B pins inputs
  localparam logic [7:0] RST_RDATA  = 8'h00;    // Read data idle value
  localparam logic [7:0] RD_UNMAP   = 8'h00;    // Answer to unmapped reads

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // One register bus request, all fields valid in the same cycle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } spio_bus_req_t;

  // Timer channel drive toward the shared port B pins
  typedef struct packed {
    logic [TMR_W-1:0][ELS_W-1:0] els;          // timer_edge_level_select
    logic [TMR_W-1:0]            out;          // Compare/PWM level
    logic [TMR_W-1:0]            oe;           // Timer wants to drive
  } spio_timer_t;

endpackage : spio_pkg

`default_nettype wire

/* File: core/spio_sync.sv */
`default_nettype none

// Two-stage level synchroniser; only the second stage is visible
module spio_sync
  import spio_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_ff;                        // First stage, read by q_ff only
  logic [W-1:0] q_ff;                           // Second stage

  // ----------------------------------------------------------------
  // Shift chain, frozen with the clock enable
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else if (ce) begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : spio_sync

`default_nettype wire

/* File: bench/spio_pin_model.sv */
`default_nettype none

// Far side of the port pins: board drive plus loopback of driven pins
module spio_pin_model
  import spio_pkg::*;
(
  input  wire logic [PA_W-1:0] pa_pin_out, // Port A drive level
  input  wire logic [PA_W-1:0] pa_pin_oe,  // Port A enables
  input  wire logic [PB_W-1:0] pb_pin_out, // Port B drive level
  input  wire logic [PB_W-1:0] pb_pin_oe,  // Port B enables
  input  wire logic [PA_W-1:0] pa_ext,     // Board drive, port A
  input  wire logic [PB_W-1:0] pb_ext,     // Board drive, port B
  output var  logic [PA_W-1:0] pa_pin_in,  // Resolved port A level
  output var  logic [PB_W-1:0] pb_pin_in   // Resolved port B level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Enabled pins show the device level; the board is weak and yields
  assign pa_pin_in = (pa_pin_oe & pa_pin_out) | (~pa_pin_oe & pa_ext);
  assign pb_pin_in = (pb_pin_oe & pb_pin_out) | (~pb_pin_oe & pb_ext);
endmodule : spio_pin_model

`default_nettype wire

/* File: bench/spio_ports_assertions.sv */
`default_nettype none

// Watches only the top ports of the port block
module spio_ports_chk
  import spio_pkg::*;
(
  input wire logic                clock,
  input wire logic                rstn,
  input wire logic                ce,
  input wire spio_bus_req_t       bus_req,
  input wire logic [DATA_W-1:0]   bus_rdata,
  input wire logic [PA_W-1:0]     pa_pin_in,
  input wire logic [PA_W-1:0]     pa_pin_out,
  input wire logic [PA_W-1:0]     pa_pin_oe,
  input wire logic [PA_W-1:0]     pa_pin_level,
  input wire logic [PB_W-1:0]     pb_pin_in,
  input wire logic [PB_W-1:0]     pb_pin_out,
  input wire logic [PB_W-1:0]     pb_pin_oe,
  input wire logic [CHS_W-1:0]    analog_channel_select,
  input wire logic [PB_W-1:0]     adc_pin_connect,
  input wire spio_timer_t         second_timer_unit,
  input wire logic [TMR_W-1:0]    second_timer_channel_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // Helpers
  // ----------
  logic [7:0] sel_hot; // Expected analog switch pattern
  logic       map_hit; // Address is one of the four registers
  assign sel_hot = (analog_channel_select < 5'h08) ? (8'h01 << analog_channel_select[2:0]) : 8'h00;
  assign map_hit = bus_req.addr inside {OFF_PA_DATA, OFF_PB_DATA, OFF_PA_DIR, OFF_PB_DIR};

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // ----------
  // Properties
  // ----------
  a_rdata_idle: assert property ($past(ce) && !$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (ce && bus_req.rd && !map_hit |=> bus_rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  a_conv_no_drive: assert property ((adc_pin_connect & (pb_pin_oe | pb_pin_out)) == 8'h00)
    else $error("converter pin is driven");
  a_adc_select: assert property (ce |=> adc_pin_connect == $past(sel_hot))
    else $error("analog switch does not follow channel select");
  a_tmr_owned: assert property (ce && second_timer_unit.els[0] != 2'h0 && analog_channel_select != 5'h06
    |=> pb_pin_oe[6] == $past(second_timer_unit.oe[0]))
    else $error("timer pin enable not taken from timer");
  a_cap_forced: assert property (ce && analog_channel_select == 5'h06 |=> !second_timer_channel_pins[0])
    else $error("timer capture not cut off by converter");
  a_pa_out_mask: assert property ((pa_pin_out & ~pa_pin_oe) == 7'h00)
    else $error("port A drives level on an input pin");
  // Sampled reset in the first term keeps the release edge, still a reset edge inside, out of the window
  a_pa_level_sync: assert property (rstn && ce ##1 ce ##1 ce |=> pa_pin_level == $past(pa_pin_in, 3))
    else $error("port A level not three edges behind pin");
  a_dir_to_oe: assert property (ce && bus_req.wr && bus_req.addr == OFF_PA_DIR ##1 ce
    |=> pa_pin_oe == $past(bus_req.wdata[6:0], 2))
    else $error("port A enables do not follow direction write");

  c_read_pa: cover property (bus_req.rd && bus_req.addr == OFF_PA_DATA);
  c_conv_sel: cover property (adc_pin_connect != 8'h00);
  c_tmr_pin: cover property (pb_pin_oe[7:6] != 2'h0 && second_timer_unit.els != 4'h0);
endmodule : spio_ports_chk

bind spio_ports spio_ports_chk i_spio_ports_chk (
  .clock(clock), .rstn(rstn), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .pa_pin_in(pa_pin_in), .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe), .pa_pin_level(pa_pin_level),
  .pb_pin_in(pb_pin_in), .pb_pin_out(pb_pin_out), .pb_pin_oe(pb_pin_oe),
  .analog_channel_select(analog_channel_select), .adc_pin_connect(adc_pin_connect),
  .second_timer_unit(second_timer_unit), .second_timer_channel_pins(second_timer_channel_pins));

`default_nettype wire

/* File: bench/spio_ports_tb.sv */
`default_nettype none

module spio_ports_tb
  import spio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clock, rstn, ce;    // Clock, reset, enable
  spio_bus_req_t bus_req;            // Register bus request
  logic [7:0]    bus_rdata;          // Read answer
  logic [6:0]    pa_in, pa_out, pa_oe, pa_lvl, pa_ext;
  logic [7:0]    pb_in, pb_out, pb_oe, pb_ext, adc, conn;
  logic [4:0]    sel;                // Converter channel
  spio_timer_t   tmr;                // Timer drive
  logic [1:0]    cap;                // Timer capture level
  int            err_count, tests_run;

  spio_ports i_spio_ports (.clock(clock), .rstn(rstn), .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pa_pin_in(pa_in), .pa_pin_out(pa_out), .pa_pin_oe(pa_oe), .pa_pin_level(pa_lvl),
    .pb_pin_in(pb_in), .pb_pin_out(pb_out), .pb_pin_oe(pb_oe), .analog_channel_select(sel),
    .adc_pin_connect(adc), .second_timer_unit(tmr), .second_timer_channel_pins(cap));
  spio_pin_model i_spio_pin_model (.pa_pin_out(pa_out), .pa_pin_oe(pa_oe), .pb_pin_out(pb_out),
    .pb_pin_oe(pb_oe), .pa_ext(pa_ext), .pb_ext(pb_ext), .pa_pin_in(pa_in), .pb_pin_in(pb_in));

  // 100 MHz clock
  always #5 clock = ~clock;

  // ----------
  // Tasks
  // ----------
  task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus_req <= '{a, d, 1'b0, 1'b0};
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input string n, input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    chk(n, bus_rdata, e);
  endtask : rd

  // Covers register, synchroniser and pin output lag
  task automatic settle();
    repeat (4) @(posedge clock);
    #1;
  endtask : settle

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  // Hang guard, well beyond the roughly 250 cycles used
  initial begin
    repeat (6000) @(posedge clock);
    err_count++;
    results();
  end

  // ----------
  // Tests
  // ----------
  initial begin
    clock = 1'b0; rstn = 1'b0; ce = 1'b1; bus_req = '0; sel = 5'h1F; tmr = '0;
    pa_ext = 7'h2A; pb_ext = 8'hA5; err_count = 0; tests_run = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    settle();
    chk("pa_oe", {1'b0, pa_oe}, 8'h00);
    chk("pb_oe", pb_oe, 8'h00);
    rd("pa_dir", OFF_PA_DIR, 8'h00);
    rd("pb_dir", OFF_PB_DIR, 8'h00);
    rd("pa_pin", OFF_PA_DATA, 8'h2A);
    rd("unmapped", 16'h0002, 8'h00);
    $display("reset test done");
    // Latch written while input: stored, not driven
    wr(OFF_PA_DATA, 8'hD5);
    settle();
    chk("pa_out", {1'b0, pa_out}, 8'h00);
    rd("pa_hold", OFF_PA_DATA, 8'h2A);
    wr(OFF_PA_DIR, 8'h8F);
    settle();
    chk("pa_oe", {1'b0, pa_oe}, 8'h0F);
    chk("pa_out", {1'b0, pa_out}, 8'h05);
    chk("pa_lvl", {1'b0, pa_lvl}, 8'h25);
    rd("pa_dir7", OFF_PA_DIR, 8'h0F);
    rd("pa_mix", OFF_PA_DATA, 8'h25);
    wr(OFF_PB_DATA, 8'h3C);
    wr(OFF_PB_DIR, 8'h0F);
    settle();
    chk("pb_oe", pb_oe, 8'h0F);
    chk("pb_out", pb_out, 8'h0C);
    rd("pb_mix", OFF_PB_DATA, 8'hAC);
    $display("data test done");
    // Second reset: directions clear, latches keep contents
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    settle();
    chk("pa_oe", {1'b0, pa_oe}, 8'h00);
    rd("pb_dir", OFF_PB_DIR, 8'h00);
    wr(OFF_PA_DIR, 8'h7F);
    wr(OFF_PB_DIR, 8'hFF);
    settle();
    chk("pa_oe", {1'b0, pa_oe}, 8'h7F);
    rd("pa_keep", OFF_PA_DATA, 8'h55);
    rd("pb_keep", OFF_PB_DATA, 8'h3C);
    $display("persistence test done");
    // Channel codes 0 to 8 with both direction settings
    for (int d = 0; d < 2; d++) begin
      wr(OFF_PB_DIR, d ? 8'h00 : 8'hFF);
      for (int c = 0; c < 9; c++) begin
        @(posedge clock);
        sel <= c[4:0];
        settle();
        conn = (c < 8) ? (8'h01 << c) : 8'h00;
        chk("adc", adc, conn);
        chk("pb_oe", pb_oe, d ? 8'h00 : ~conn);
        rd("pb_conv", OFF_PB_DATA, d ? (8'hA5 & ~conn) : 8'h3C);
      end
    end
    $display("converter test done");
    // Timer owns the top pins while directions stay input
    @(posedge clock);
    sel <= 5'h1F;
    tmr <= '{4'h9, 2'h3, 2'h3};
    settle();
    chk("tmr_oe", pb_oe, 8'hC0);
    chk("tmr_out", pb_out, 8'hC0);
    chk("cap", {6'h00, cap}, 8'h03);
    rd("pb_tmr", OFF_PB_DATA, 8'hE5);
    // Converter wins a live timer pin
    @(posedge clock);
    sel <= 5'h06;
    settle();
    chk("tmr_oe", pb_oe, 8'h80);
    chk("adc", adc, 8'h40);
    chk("cap", {6'h00, cap}, 8'h02);
    @(posedge clock);
    tmr <= '0;
    settle();
    @(posedge clock);
    sel <= 5'h07;
    settle();
    chk("pb_oe", pb_oe, 8'h00);
    chk("adc", adc, 8'h80);
    $display("timer test done");
    // Clock enable low: a direction write must be ignored
    @(posedge clock);
    ce <= 1'b0;
    wr(OFF_PA_DIR, 8'h00);
    @(posedge clock);
    ce <= 1'b1;
    settle();
    chk("pa_oe_frz", {1'b0, pa_oe}, 8'h7F);
    rd("pa_dir_frz", OFF_PA_DIR, 8'h7F);
    $display("freeze test done");
    results();
  end
endmodule : spio_ports_tb

`default_nettype wire
